// File: common/sar_seq_pkg.sv
// package: register map, field layout, timing constants and carriers
package sar_seq_pkg;

  // ***********************************************************
  // register map (byte addresses on the apb bus)
  // ***********************************************************
  localparam logic [7:0] OFF_CONTROL_STATUS = 8'h00; // control and status
  localparam logic [7:0] OFF_INPUT_SELECT   = 8'h04; // temporary select
  localparam logic [7:0] OFF_RESULT_LOW     = 8'h08; // low result byte
  localparam logic [7:0] OFF_RESULT_HIGH    = 8'h0C; // high result byte

  // ***********************************************************
  // control/status bit positions
  // ***********************************************************
  localparam int BIT_CONVERTER_ON = 7;   // converter_on
  localparam int BIT_START        = 6;   // conversion_start
  localparam int BIT_FREE_RUN     = 5;   // free_run_select
  localparam int BIT_DONE         = 4;   // conversion_done_flag
  localparam int BIT_IRQ_ENABLE   = 3;   // done_irq_enable
  localparam int DIV_MSB          = 2;   // clock_divider_select msb

  // ***********************************************************
  // reset values and selection codes
  // ***********************************************************
  localparam logic [7:0] CTRL_RESET   = 8'h00; // control after reset
  localparam logic [7:0] SELECT_RESET = 8'h00; // select after reset
  localparam logic [4:0] DIFF_FIRST   = 5'h0B; // first differential code
  localparam logic [4:0] DIFF_LAST    = 5'h1D; // last differential code

  // ***********************************************************
  // conversion timing in converter clock cycles
  // ***********************************************************
  localparam logic [4:0] NORMAL_LAST   = 5'h0C; // 13 cycles, last index
  localparam logic [4:0] EXTENDED_LAST = 5'h18; // 25 cycles, last index
  localparam logic [4:0] NORMAL_HOLD   = 5'h01; // hold at 1.5 cycles
  localparam logic [4:0] EXTENDED_HOLD = 5'h0D; // hold at 13.5 cycles
  localparam logic [9:0] FIRST_TRIAL   = 10'h200; // msb trial weight
  localparam int PRESCALE_WIDTH = 7;            // divide by up to 128

  // ***********************************************************
  // carriers
  // ***********************************************************
  typedef struct packed {
    logic [1:0] reference_select;    // reference choice
    logic       left_align;          // result alignment
    logic [4:0] channel_gain_select; // channel and gain
  } input_select_s;

endpackage

// File: core/converter_prescaler.sv
// converter clock prescaler with rising and falling edge ticks
`timescale 1ns/100ps
module converter_prescaler #(
  parameter int WIDTH = sar_seq_pkg::PRESCALE_WIDTH
) (
  input  wire logic       clk_i,     // system clock
  input  wire logic       srst_i,    // synchronous reset
  input  wire logic       ce_i,      // clock enable
  input  wire logic       on_i,      // converter switched on
  input  wire logic [2:0] div_sel_i, // division select
  output logic            rise_o,    // converter clock rising edge
  output logic            fall_o     // converter clock falling edge
);

  logic [WIDTH-1:0] count_reg;  // free-running divider
  logic             prev_reg;   // tap value one cycle ago
  logic [2:0]       tap_index;  // tapped counter bit
  logic             tap_bit;    // current tap level

  // ratio 2 for codes 0 and 1, doubling per code above
  assign tap_index = (div_sel_i == 3'h0) ? 3'h0 : div_sel_i - 3'h1;
  assign tap_bit   = count_reg[tap_index];
  assign rise_o    = tap_bit & ~prev_reg;
  assign fall_o    = ~tap_bit & prev_reg;

  // ***********************************************************
  // counter, held in reset while the converter is off
  // ***********************************************************
  always_ff @(posedge clk_i) begin
    if (srst_i || (ce_i && !on_i)) begin
      count_reg <= '0;
      prev_reg  <= 1'b0;
    end else if (ce_i) begin
      count_reg <= count_reg + 1'b1;
      prev_reg  <= tap_bit;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  chk_prescaler_held: assert property (
    !on_i && ce_i |=> !rise_o && !fall_o)
    else $error("prescaler ran while converter off");

endmodule // converter_prescaler

// File: core/result_holder.sv
// result holder with low-then-high read lock
`timescale 1ns/100ps
module result_holder #(
  parameter int WIDTH = 10
) (
  input  wire logic             clk_i,     // system clock
  input  wire logic             srst_i,    // synchronous reset
  input  wire logic             ce_i,      // clock enable
  input  wire logic             write_i,   // conversion complete
  input  wire logic [WIDTH-1:0] data_i,    // finished code
  input  wire logic             rd_low_i,  // low byte read
  input  wire logic             rd_high_i, // high byte read
  output logic      [WIDTH-1:0] result_o,  // stored code
  output logic                  locked_o   // updates blocked
);

  logic [WIDTH-1:0] result_reg; // stored code
  logic             lock_reg;   // set by low read, cleared by high

  assign result_o = result_reg;
  assign locked_o = lock_reg;

  // ***********************************************************
  // store and lock
  // ***********************************************************
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      result_reg <= '0;
      lock_reg   <= 1'b0;
    end else if (ce_i) begin
      if (write_i && !lock_reg) begin
        result_reg <= data_i;
      end
      if (rd_low_i) begin
        lock_reg <= 1'b1;
      end else if (rd_high_i) begin
        lock_reg <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  chk_lock_blocks: assert property (
    lock_reg && !rd_high_i |=> $stable(result_reg))
    else $error("result changed while locked");

endmodule // result_holder

// File: core/sar_converter_sequencer.sv
// successive-approximation converter sequencer with apb registers
//
// Contract
// - prescaler runs only while converter on
// - start waits for next converter clock rise
// - differential starts only on alternate rises
// - normal conversion lasts 13 converter cycles
// - first conversion after enable lasts 25
// - hold at 1.5 or 13.5 cycles
// - completion stores result, flags, clears start
// - free-run restarts at once, start stays set; a differential channel restarts one converter clock rise later
// - selections copied from temporary while idle
// - selection frozen until final conversion cycle
// - cpu halt in sleep starts a conversion
// - sleep conversion completion raises wake interrupt
// - single-ended code scales input to reference
// - differential code saturates at zero
// - mode bit picks single or free-running
// - low read blocks updates until high read
// - result right aligned, left when bit set
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/100ps
module sar_converter_sequencer #(
  parameter int ADDR_WIDTH = 8,  // apb address width
  parameter int CODE_WIDTH = 10  // converter resolution
) (
  input  wire logic                  clk_i,           // 40 MHz clock
  input  wire logic                  srst_i,          // sync reset
  input  wire logic                  ce_i,            // clock enable
  // apb slave
  input  wire logic                  psel,            // select
  input  wire logic                  penable,         // access phase
  input  wire logic                  pwrite,          // write
  input  wire logic [ADDR_WIDTH-1:0] paddr,           // byte address
  input  wire logic [31:0]           pwdata,          // write data
  output logic      [31:0]           prdata,          // read data
  output logic                       pready,          // ready
  output logic                       pslverr,         // error
  // cpu side
  input  wire logic                  sleep_halted_i,  // cpu halted
  input  wire logic                  irq_ack_i,       // irq serviced
  output logic                       done_irq_o,      // completion irq
  // analog side
  input  wire logic                  compare_i,       // input >= trial
  output logic      [4:0]            channel_gain_o,  // working channel
  output logic      [1:0]            reference_o,     // working reference
  output logic                       analog_on_o,     // analog enable
  output logic                       sample_hold_o,   // hold pulse
  output logic      [CODE_WIDTH-1:0] trial_code_o     // dac trial code
);

  // ***********************************************************
  // state
  // ***********************************************************
  logic                    on_reg;        // converter_on
  logic                    start_reg;     // conversion_start
  logic                    free_reg;      // free_run_select
  logic                    done_reg;      // conversion_done_flag
  logic                    irqen_reg;     // done_irq_enable
  logic [2:0]              div_reg;       // clock_divider_select
  sar_seq_pkg::input_select_s temp_reg;   // input_select_reg
  sar_seq_pkg::input_select_s work_reg;   // working selection
  logic                    busy_reg;      // conversion running
  logic                    ext_reg;       // running extended
  logic                    first_reg;     // next one is extended
  logic [4:0]              cyc_reg;       // rises since start
  logic [CODE_WIDTH-1:0]   trial_reg;     // trial code
  logic [CODE_WIDTH-1:0]   mask_reg;      // bit under test
  logic                    par_reg;       // rise parity since on
  logic                    hold_reg;      // sample_hold pulse
  logic                    irq_reg;       // interrupt output
  logic                    halt_prev_reg; // halt seen last cycle
  logic                    pready_reg;    // apb ready
  logic [31:0]             prdata_reg;    // apb read data
  logic                    pslverr_reg;   // apb error

  // ***********************************************************
  // decode and control terms
  // ***********************************************************
  wire logic rise_tick;          // converter clock rising edge
  wire logic fall_tick;          // converter clock falling edge
  wire logic [CODE_WIDTH-1:0] result_val; // stored code
  wire logic result_locked;      // result lock status

  wire logic [7:0] addr8       = paddr[7:0];
  wire logic hit_ctrl          = addr8 == sar_seq_pkg::OFF_CONTROL_STATUS;
  wire logic hit_sel           = addr8 == sar_seq_pkg::OFF_INPUT_SELECT;
  wire logic hit_low           = addr8 == sar_seq_pkg::OFF_RESULT_LOW;
  wire logic hit_high          = addr8 == sar_seq_pkg::OFF_RESULT_HIGH;
  wire logic hit_any           = hit_ctrl | hit_sel | hit_low | hit_high;
  wire logic bus_fire          = ce_i & psel & penable & pready_reg;
  wire logic wr_fire           = bus_fire & pwrite & hit_any;
  wire logic rd_fire           = bus_fire & ~pwrite;
  wire logic wr_ctrl           = wr_fire & hit_ctrl;
  wire logic wr_sel            = wr_fire & hit_sel;
  wire logic rd_low            = rd_fire & hit_low;
  wire logic rd_high           = rd_fire & hit_high;

  // differential codes come from the working channel
  wire logic is_diff = work_reg.channel_gain_select >=
                       sar_seq_pkg::DIFF_FIRST &&
                       work_reg.channel_gain_select <=
                       sar_seq_pkg::DIFF_LAST;
  wire logic [4:0] last_cyc = ext_reg ? sar_seq_pkg::EXTENDED_LAST
                                      : sar_seq_pkg::NORMAL_LAST;
  wire logic [4:0] hold_cyc = ext_reg ? sar_seq_pkg::EXTENDED_HOLD
                                      : sar_seq_pkg::NORMAL_HOLD;
  wire logic complete = busy_reg & rise_tick & (cyc_reg == last_cyc);
  wire logic edge_ok  = ~is_diff | ~par_reg;
  wire logic start_now = on_reg & start_reg & rise_tick & edge_ok &
                         (~busy_reg | (complete & free_reg));
  wire logic hold_now = busy_reg & fall_tick & (cyc_reg == hold_cyc);
  wire logic step_now = busy_reg & rise_tick & (|mask_reg) & ~complete;
  wire logic unlock   = ~busy_reg | (cyc_reg == last_cyc);
  wire logic sleep_go = sleep_halted_i & ~halt_prev_reg & on_reg &
                        ~busy_reg & ~start_reg & ~free_reg & irqen_reg;

  // next values of software-visible control
  wire logic on_next    = wr_ctrl ? pwdata[sar_seq_pkg::BIT_CONVERTER_ON]
                                  : on_reg;
  wire logic start_set  = (wr_ctrl & pwdata[sar_seq_pkg::BIT_START]) |
                          sleep_go;
  wire logic done_clear = irq_ack_i |
                          (wr_ctrl & pwdata[sar_seq_pkg::BIT_DONE]);
  wire logic done_next  = complete | (done_reg & ~done_clear);
  wire logic irqen_next = wr_ctrl ? pwdata[sar_seq_pkg::BIT_IRQ_ENABLE]
                                  : irqen_reg;

  // next trial after one comparison
  wire logic [CODE_WIDTH-1:0] kept  = compare_i ? trial_reg
                                                : trial_reg & ~mask_reg;
  wire logic [CODE_WIDTH-1:0] mask_half = mask_reg >> 1;

  // formatted result bytes
  wire logic [7:0] low_byte  = temp_reg.left_align
                               ? {result_val[1:0], 6'h00}
                               : result_val[7:0];
  wire logic [7:0] high_byte = temp_reg.left_align
                               ? result_val[9:2]
                               : {6'h00, result_val[9:8]};
  wire logic [7:0] ctrl_byte = {on_reg, start_reg, free_reg, done_reg,
                                irqen_reg, div_reg};
  wire logic [7:0] read_byte = hit_ctrl ? ctrl_byte
                             : hit_sel  ? temp_reg
                             : hit_low  ? low_byte
                             : hit_high ? high_byte
                             : 8'h00;

  // ***********************************************************
  // submodules
  // ***********************************************************
  converter_prescaler #(
    .WIDTH     (sar_seq_pkg::PRESCALE_WIDTH)
  ) u_prescaler (
    .clk_i     (clk_i),
    .srst_i    (srst_i),
    .ce_i      (ce_i),
    .on_i      (on_reg),
    .div_sel_i (div_reg),
    .rise_o    (rise_tick),
    .fall_o    (fall_tick)
  );

  result_holder #(
    .WIDTH     (CODE_WIDTH)
  ) u_result (
    .clk_i     (clk_i),
    .srst_i    (srst_i),
    .ce_i      (ce_i),
    .write_i   (complete),
    .data_i    (trial_reg),
    .rd_low_i  (rd_low),
    .rd_high_i (rd_high),
    .result_o  (result_val),
    .locked_o  (result_locked)
  );

  // ***********************************************************
  // apb slave: one wait state, then answer
  // ***********************************************************
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (ce_i) begin
      pready_reg <= psel & penable & ~pready_reg;
      if (psel && penable && !pready_reg) begin
        prdata_reg  <= {24'h000000, read_byte};
        pslverr_reg <= ~hit_any;  // unmapped address
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  // ***********************************************************
  // control and status bits
  // ***********************************************************
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      on_reg    <= sar_seq_pkg::CTRL_RESET[sar_seq_pkg::BIT_CONVERTER_ON];
      start_reg <= sar_seq_pkg::CTRL_RESET[sar_seq_pkg::BIT_START];
      free_reg  <= sar_seq_pkg::CTRL_RESET[sar_seq_pkg::BIT_FREE_RUN];
      done_reg  <= sar_seq_pkg::CTRL_RESET[sar_seq_pkg::BIT_DONE];
      irqen_reg <= sar_seq_pkg::CTRL_RESET[sar_seq_pkg::BIT_IRQ_ENABLE];
      div_reg   <= sar_seq_pkg::CTRL_RESET[sar_seq_pkg::DIV_MSB:0];
      irq_reg   <= 1'b0;
      halt_prev_reg <= 1'b0;
    end else if (ce_i) begin
      on_reg    <= on_next;
      halt_prev_reg <= sleep_halted_i;
      if (wr_ctrl) begin
        free_reg <= pwdata[sar_seq_pkg::BIT_FREE_RUN];
        div_reg  <= pwdata[sar_seq_pkg::DIV_MSB:0];
      end
      irqen_reg <= irqen_next;
      // start: set wins over the hardware clear
      if (!on_next) begin
        start_reg <= 1'b0;
      end else if (start_set) begin
        start_reg <= 1'b1;
      end else if (complete && !free_reg) begin
        start_reg <= 1'b0;
      end
      done_reg <= done_next;
      irq_reg  <= done_next & irqen_next;
    end
  end

  // ***********************************************************
  // selection: temporary copy and working copy
  // ***********************************************************
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      temp_reg <= sar_seq_pkg::SELECT_RESET;
      work_reg <= sar_seq_pkg::SELECT_RESET;
    end else if (ce_i) begin
      if (wr_sel) begin
        temp_reg <= pwdata[7:0];
      end
      if (unlock && !start_now) begin
        work_reg <= temp_reg;
      end
    end
  end

  // ***********************************************************
  // conversion sequencing
  // ***********************************************************
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      busy_reg  <= 1'b0;
      ext_reg   <= 1'b0;
      first_reg <= 1'b1;
      cyc_reg   <= 5'h00;
      par_reg   <= 1'b0;
    end else if (ce_i) begin
      if (!on_reg) begin
        busy_reg  <= 1'b0;
        first_reg <= 1'b1;
        cyc_reg   <= 5'h00;
        par_reg   <= 1'b0;
      end else begin
        if (rise_tick) begin
          par_reg <= ~par_reg;
        end
        if (start_now) begin
          busy_reg  <= 1'b1;
          ext_reg   <= first_reg;
          first_reg <= 1'b0;
          cyc_reg   <= 5'h00;
        end else if (complete) begin
          busy_reg <= 1'b0;
        end else if (busy_reg && rise_tick) begin
          cyc_reg <= cyc_reg + 5'h01;
        end
      end
    end
  end

  // ***********************************************************
  // sample-and-hold and approximation
  // ***********************************************************
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      hold_reg  <= 1'b0;
      trial_reg <= '0;
      mask_reg  <= '0;
    end else if (ce_i) begin
      hold_reg <= hold_now;
      if (start_now) begin
        trial_reg <= '0;
        mask_reg  <= '0;
      end else if (hold_now) begin
        trial_reg <= sar_seq_pkg::FIRST_TRIAL;
        mask_reg  <= sar_seq_pkg::FIRST_TRIAL;
      end else if (step_now) begin
        trial_reg <= kept | mask_half;
        mask_reg  <= mask_half;
      end
    end
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  assign prdata         = prdata_reg;
  assign pready         = pready_reg;
  assign pslverr        = pslverr_reg;
  assign done_irq_o     = irq_reg;
  assign channel_gain_o = work_reg.channel_gain_select;
  assign reference_o    = work_reg.reference_select;
  assign analog_on_o    = on_reg;
  assign sample_hold_o  = hold_reg;
  assign trial_code_o   = trial_reg;

  // ***********************************************************
  // checks
  // ***********************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  chk_start_on_rise: assert property (
    $rose(busy_reg) |-> $past(rise_tick && on_reg && start_reg))
    else $error("start not on converter clock rise");

  chk_diff_alternate: assert property (
    ce_i && start_now && is_diff |-> !par_reg)
    else $error("differential start on wrong edge");

  chk_length_fixed: assert property (
    ce_i && complete && !ext_reg |-> cyc_reg == 5'h0C)
    else $error("normal conversion length wrong");

  chk_first_extended: assert property (
    ce_i && start_now && first_reg |=> ext_reg && busy_reg)
    else $error("first conversion not extended");

  chk_hold_point: assert property (
    ce_i && hold_now |-> fall_tick &&
      cyc_reg == (ext_reg ? 5'h0D : 5'h01))
    else $error("sample-and-hold at wrong point");

  chk_single_clear: assert property (
    ce_i && complete && !free_reg && !start_set && on_next
      |=> done_reg && !start_reg)
    else $error("single completion did not flag and clear");

  chk_free_restart: assert property (
    ce_i && complete && free_reg && on_reg && edge_ok
      |=> busy_reg && start_reg && cyc_reg == 5'h00)
    else $error("free-running did not restart");

  chk_select_frozen: assert property (
    ce_i && busy_reg && !unlock |=> $stable(work_reg))
    else $error("selection changed mid conversion");

  chk_align_read: assert property (
    ce_i && psel && penable && !pready_reg && hit_high &&
      !temp_reg.left_align |=> prdata_reg[7:2] == 6'h00)
    else $error("right-aligned high byte not padded");

endmodule // sar_converter_sequencer

// File: verif/analog_model.sv
// analog side model: comparator against a held input code
`timescale 1ns/100ps
module analog_model (
  input  wire logic       clk_i,    // system clock
  input  wire logic       hold_i,   // sample-and-hold pulse
  input  wire logic [9:0] vin_i,    // live input as a code
  input  wire logic [9:0] trial_i,  // trial code from the array
  output logic            compare_o // held input >= trial
);
  logic [9:0] held_reg; // input held for the whole conversion
  // capture the live input only at the hold pulse
  always_ff @(posedge clk_i) begin
    if (hold_i) begin
      held_reg <= vin_i;
    end
  end
  // track the live input while the hold pulse stands, held value after
  assign compare_o = ((hold_i ? vin_i : held_reg) >= trial_i);
endmodule // analog_model

// File: verif/tb.sv
// testbench: apb driven conversions checked against the input code
`timescale 1ns/100ps
module tb;
  logic clk_i, srst_i, ce_i, psel, penable, pwrite, pready, pslverr;
  logic sleep_halted_i, irq_ack_i, done_irq_o, compare_i, analog_on_o;
  logic sample_hold_o, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, lo;
  logic [4:0]  channel_gain_o;
  logic [1:0]  reference_o;
  logic [9:0]  trial_code_o, vin, code;
  logic [2:0]  div;
  logic [4:0]  sel;
  int error_cnt, check_count, cyc, holds, k, n;
  sar_converter_sequencer sar_converter_sequencer_i (.clk_i(clk_i),
    .srst_i(srst_i), .ce_i(ce_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_halted_i(sleep_halted_i),
    .irq_ack_i(irq_ack_i), .done_irq_o(done_irq_o), .compare_i(compare_i),
    .channel_gain_o(channel_gain_o), .reference_o(reference_o),
    .analog_on_o(analog_on_o), .sample_hold_o(sample_hold_o),
    .trial_code_o(trial_code_o));
  analog_model analog_model_i (.clk_i(clk_i), .hold_i(sample_hold_o),
    .vin_i(vin), .trial_i(trial_code_o), .compare_o(compare_i));
  always #12.5 clk_i = ~clk_i; // 40 MHz
  // cycle ceiling and hold pulse count
  always @(posedge clk_i) begin
    cyc++;
    if (sample_hold_o === 1'b1 && ce_i) holds++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  // expected result bytes: high byte word above low byte word
  function automatic logic [63:0] bytes_of(input logic [9:0] c,
                                           input logic left);
    bytes_of = left ? {24'h0, c[9:2], 24'h0, c[1:0], 6'h0}
                    : {30'h0, c[9:8], 24'h0, c[7:0]};
  endfunction
  // one apb transfer: idle edge, setup edge, access until pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic finish_test();
    if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {clk_i, psel, penable, pwrite, paddr, pwdata, vin} = '0;
    {srst_i, ce_i, sleep_halted_i, irq_ack_i} = 4'h C;
    {error_cnt, check_count, cyc, holds} = '0;
    void'($urandom(32'hA3ACC3AF));
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    apb(1'b1, 8'h10, 32'h000000FF);
    check(e, 1'b1);
    for (k = 0; k < 6; k++) begin
      code = (k == 0) ? 10'h3FF : (k == 1) ? 10'h000 : 10'($urandom);
      div  = 3'($urandom % 4);
      sel  = (k == 5) ? sar_seq_pkg::DIFF_FIRST : 5'h00;
      vin <= code;
      apb(1'b1, sar_seq_pkg::OFF_INPUT_SELECT,
          {26'h0, k[0], sel});
      // differential gain stage settles before the start
      if (k == 5) repeat (5000) @(posedge clk_i);
      apb(1'b1, sar_seq_pkg::OFF_CONTROL_STATUS, 32'h000000D0 | div);
      // freeze all state a few cycles; the result must not suffer
      ce_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      ce_i <= 1'b1;
      do begin
        apb(1'b0, sar_seq_pkg::OFF_CONTROL_STATUS, 32'h0);
      end while (q[4] !== 1'b1);
      check(q[6], 1'b0);
      check(done_irq_o, 1'b0);
      check(holds, k + 1);
      apb(1'b0, sar_seq_pkg::OFF_RESULT_LOW, 32'h0);
      lo = q;
      apb(1'b0, sar_seq_pkg::OFF_RESULT_HIGH, 32'h0);
      // expected bytes for right and left alignment
      if (k[0]) check({q, lo}, bytes_of(code, 1'b1));
      else check({q, lo}, bytes_of(code, 1'b0));
      apb(1'b1, sar_seq_pkg::OFF_CONTROL_STATUS, 32'h00000090);
    end
    // free-running on channel 0: two holds with no new start
    apb(1'b1, sar_seq_pkg::OFF_INPUT_SELECT, 32'h0);
    n = holds;
    apb(1'b1, sar_seq_pkg::OFF_CONTROL_STATUS, 32'h000000F0);
    do begin
      @(posedge clk_i);
    end while (holds < n + 2);
    apb(1'b0, sar_seq_pkg::OFF_CONTROL_STATUS, 32'h0);
    check(q[6], 1'b1);
    check(q[5], 1'b1);
    apb(1'b1, sar_seq_pkg::OFF_CONTROL_STATUS, 32'h00000010);
    apb(1'b0, sar_seq_pkg::OFF_RESULT_LOW, 32'h0);
    lo = q;
    apb(1'b0, sar_seq_pkg::OFF_RESULT_HIGH, 32'h0);
    check({q, lo}, bytes_of(code, 1'b0));
    // sleep-triggered conversion wakes through the done interrupt
    apb(1'b1, sar_seq_pkg::OFF_CONTROL_STATUS, 32'h00000098);
    n = holds;
    sleep_halted_i <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (done_irq_o !== 1'b1);
    sleep_halted_i <= 1'b0;
    check(holds, n + 1);
    irq_ack_i <= 1'b1;
    @(posedge clk_i);
    irq_ack_i <= 1'b0;
    apb(1'b0, sar_seq_pkg::OFF_CONTROL_STATUS, 32'h0);
    check(q[4], 1'b0);
    check(done_irq_o, 1'b0);
    finish_test();
  end
endmodule // tb
